// File: pot_pkg.sv
package pot_pkg;
   localparam int unsigned FRAME_BITS      = 16;
   localparam int unsigned DATA_BITS       = 10;
   localparam int unsigned CMD_MSB         = 13;
   localparam int unsigned CMD_LSB         = 10;
   localparam int unsigned CTL_UNLOCK_BIT  = 1;
   localparam int unsigned CTL_CALIB_BIT   = 2;
   localparam int unsigned SHDN_BIT        = 0;
   localparam logic [9:0]  WIPER_MIDSCALE  = 10'h200;
   localparam logic [9:0]  CTL_RESET       = 10'h000;
   localparam logic [15:0] HIZ_PREP_WORD   = 16'h8001;
   localparam logic [3:0]  BIT_CNT_RESET   = 4'h0;
   localparam logic [3:0]  BIT_CNT_LAST    = 4'hF;
   localparam logic [3:0]  RDY_DELAY_CYC   = 4'h4;
   // Pin order sclk, select, din, reset pin; select idles high
   localparam logic [3:0]  PIN_IDLE        = 4'h4;

   // Bit codes are not the command numbers from 3 upwards
   typedef enum logic [3:0] {
      CMD_NOP        = 4'h0,
      CMD_WIPER_WR   = 4'h1,
      CMD_WIPER_RD   = 4'h2,
      CMD_SOFT_RST   = 4'h4,
      CMD_CTL_WR     = 4'h6,
      CMD_CTL_RD     = 4'h7,
      CMD_SHUTDOWN   = 4'h8
   } cmd_t;
endpackage

// File: pin_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for a bundle of pin inputs
module pin_sync #(
   parameter int unsigned  W       = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // Reset to the pins' idle levels so no edge appears on release
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meta_q   <= RST_VAL;
         sync_out <= RST_VAL;
      end else if (clk_en) begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// File: pot_serial_decoder.sv
`timescale 1ns/10ps
// How it works
// (RULE_01) Frame bits 13..10 are the command, bits 9..0 the data field.
// (RULE_02) Command 0 changes nothing.
// (RULE_03) Command 1 loads data into wiper register only when unlocked.
// (RULE_04) Command 2 returns the wiper value in the next frame.
// (RULE_05) Command 3 reloads midscale into the wiper regardless of lock.
// (RULE_06) Command 4 writes data bits 2 and 1 into control register.
// (RULE_07) Command 5 returns the control register in the next frame.
// (RULE_08) Command 6 sets shutdown from data bit 0.
// (RULE_09) Shutdown opens terminal A, grounds wiper to B; commands still work.
// (RULE_10) Rising edge of the reset pin loads midscale into the wiper.
// (RULE_11) Software or hardware reset restores control register defaults.
// (RULE_12) Control bit 1 unlocks wiper writes; default locked.
// (RULE_13) Control bit 2 at 0 selects calibrated mode; default 0.
// (RULE_14) Ready output rises once a wiper write has completed.
// (RULE_15) Ready output rises once a readback value is prepared.
// (RULE_16) Host may wait a fixed delay instead of watching ready.
// (RULE_17) Serial output changes on rising serial clock edges.
// (RULE_18) Outside readback the previous frame's word is echoed out.
// (RULE_19) After readback the next frame carries the value in bits 9..0.
// (RULE_20) Word 0x8001 then a no-op frame leaves serial output released.
// (RULE_21) Serial output is open-drain: drive low or release.
// (RULE_22) Two chained parts: 32 clocks, far part's word first.
// (RULE_23) Bits enter MSB first on falling clock edges while select low.
// (RULE_24) Decode on select rising after 16 clocks; earlier rise discards.
// (RULE_25) Frames are whole multiples of 16 clocks.
// (RULE_26) Wiper register powers up at midscale.
// (RULE_27) Midscale is code 0x200.
module pot_serial_decoder (
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       clk_en,
   input  wire logic       sclk,
   input  wire logic       frame_sel_b,
   input  wire logic       din,
   input  wire logic       hw_reset,
   output logic            serial_out_o,
   output logic            serial_out_oe,
   output logic            ready_o,
   output logic            ready_oe,
   output logic [9:0]      wiper_position_reg,
   output logic            wiper_write_unlock,
   output logic            calib_disable,
   output logic            shutdown_q,
   output logic            term_a_open,
   output logic            wiper_to_b
);
   logic [3:0]  pins_s;
   logic        sclk_s;
   logic        sel_b_s;
   logic        din_s;
   logic        hwrst_s;
   logic        sclk_p_q;
   logic        sel_b_p_q;
   logic        hwrst_p_q;
   logic        sclk_fall;
   logic        sclk_rise;
   logic        sel_rise;
   logic        sel_fall;
   logic        hwrst_rise;
   logic [15:0] shift_q;
   logic [15:0] prev_word_q;
   logic [3:0]  bit_cnt_q;
   logic        full_q;
   logic        decode;
   logic [3:0]  cmd;
   logic [9:0]  data;
   logic [15:0] out_sr_q;
   logic        out_bit_q;
   logic        first_rise_q;
   logic        hiz_arm_q;
   logic        hiz_q;
   logic        rd_pend_q;
   logic [15:0] rd_word_q;
   logic [3:0]  rdy_cnt_q;
   logic        rdy_q;
   logic        dec_nop;
   logic        dec_wiper_wr;
   logic        dec_wiper_rd;
   logic        dec_soft_rst;
   logic        dec_ctl_wr;
   logic        dec_ctl_rd;
   logic        dec_shutdown;
   logic        dec_any_rd;
   logic [15:0] next_word;

   // Idle levels as reset values, so no false frame start follows reset
   pin_sync #(
      .W       (4),
      .RST_VAL (pot_pkg::PIN_IDLE)
   ) u_sync (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .clk_en   (clk_en),
      .async_in ({sclk, frame_sel_b, din, hw_reset}),
      .sync_out (pins_s)
   );
   assign sclk_s  = pins_s[3];
   assign sel_b_s = pins_s[2];
   assign din_s   = pins_s[1];
   assign hwrst_s = pins_s[0];

   // Select idles high; starting history high avoids a false frame start
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sclk_p_q  <= 1'b0;
         sel_b_p_q <= 1'b1;
         hwrst_p_q <= 1'b0;
      end else if (clk_en) begin
         sclk_p_q  <= sclk_s;
         sel_b_p_q <= sel_b_s;
         hwrst_p_q <= hwrst_s;
      end
   end

   assign sclk_fall  = sclk_p_q & ~sclk_s;
   assign sclk_rise  = ~sclk_p_q & sclk_s;
   assign sel_rise   = ~sel_b_p_q & sel_b_s;
   assign sel_fall   = sel_b_p_q & ~sel_b_s;
   assign hwrst_rise = ~hwrst_p_q & hwrst_s;   // see RULE_10

   // Input shift on falling serial clock while selected
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         shift_q   <= '0;
         bit_cnt_q <= pot_pkg::BIT_CNT_RESET;
         full_q    <= 1'b0;
      end else if (clk_en) begin
         if (sel_fall) begin
            bit_cnt_q <= pot_pkg::BIT_CNT_RESET;
            full_q    <= 1'b0;
         end else if (!sel_b_s && sclk_fall) begin
            // Counter wraps every 16 bits, so chained 32-bit frames decode too
            shift_q   <= {shift_q[14:0], din_s};   // see RULE_23
            bit_cnt_q <= bit_cnt_q + 4'h1;          // see RULE_25
            full_q    <= (bit_cnt_q == pot_pkg::BIT_CNT_LAST);
         end
      end
   end

   // Only whole multiples of 16 bits decode; a short frame is dropped
   assign decode = sel_rise & full_q & (bit_cnt_q == pot_pkg::BIT_CNT_RESET);  // see RULE_24
   assign cmd    = shift_q[pot_pkg::CMD_MSB:pot_pkg::CMD_LSB];  // see RULE_01
   assign data   = shift_q[pot_pkg::DATA_BITS-1:0];

   // One strobe per command; codes outside the table raise none
   assign dec_nop      = decode & (cmd == pot_pkg::CMD_NOP);   // see RULE_02
   assign dec_wiper_wr = decode & (cmd == pot_pkg::CMD_WIPER_WR);
   assign dec_wiper_rd = decode & (cmd == pot_pkg::CMD_WIPER_RD);
   assign dec_soft_rst = decode & (cmd == pot_pkg::CMD_SOFT_RST);
   assign dec_ctl_wr   = decode & (cmd == pot_pkg::CMD_CTL_WR);
   assign dec_ctl_rd   = decode & (cmd == pot_pkg::CMD_CTL_RD);
   assign dec_shutdown = decode & (cmd == pot_pkg::CMD_SHUTDOWN);
   assign dec_any_rd   = dec_wiper_rd | dec_ctl_rd;

   // Readback outranks the echo for one frame only
   assign next_word = rd_pend_q ? rd_word_q : prev_word_q;

   // Wiper register
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wiper_position_reg <= pot_pkg::WIPER_MIDSCALE;   // see RULE_26, RULE_27
      end else if (clk_en) begin
         // Pin reset outranks a command decoded in the same cycle
         if (hwrst_rise) begin
            wiper_position_reg <= pot_pkg::WIPER_MIDSCALE;   // see RULE_10
         end else if (dec_soft_rst) begin
            wiper_position_reg <= pot_pkg::WIPER_MIDSCALE;   // see RULE_05
         end else if (dec_wiper_wr && wiper_write_unlock) begin
            wiper_position_reg <= data;   // see RULE_03, RULE_12
         end
      end
   end

   // Control register; NOP and other codes leave it alone
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wiper_write_unlock <= pot_pkg::CTL_RESET[pot_pkg::CTL_UNLOCK_BIT];
         calib_disable      <= pot_pkg::CTL_RESET[pot_pkg::CTL_CALIB_BIT];
      end else if (clk_en) begin
         if (hwrst_rise || dec_soft_rst) begin
            wiper_write_unlock <= pot_pkg::CTL_RESET[pot_pkg::CTL_UNLOCK_BIT];   // see RULE_11
            calib_disable      <= pot_pkg::CTL_RESET[pot_pkg::CTL_CALIB_BIT];
         end else if (dec_ctl_wr) begin
            wiper_write_unlock <= data[pot_pkg::CTL_UNLOCK_BIT];   // see RULE_06, RULE_12
            calib_disable      <= data[pot_pkg::CTL_CALIB_BIT];    // see RULE_13
         end
      end
   end

   // Shutdown state; decode is not gated so all commands still work
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         shutdown_q <= 1'b0;
      end else if (clk_en) begin
         // Pin and command resets leave shutdown alone
         if (dec_shutdown) begin
            shutdown_q <= data[pot_pkg::SHDN_BIT];   // see RULE_08, RULE_09
         end
      end
   end
   assign term_a_open = shutdown_q;   // see RULE_09
   assign wiper_to_b  = shutdown_q;

   // Word to send next frame: readback value or echo of this frame
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prev_word_q <= '0;
         rd_pend_q   <= 1'b0;
         rd_word_q   <= '0;
      end else if (clk_en) begin
         if (decode) begin
            prev_word_q <= shift_q;   // see RULE_18
            rd_pend_q   <= dec_any_rd;
            if (dec_wiper_rd) begin
               rd_word_q <= {6'h00, wiper_position_reg};   // see RULE_04, RULE_19
            end else begin
               // Control readback keeps each bit at its own position
               rd_word_q <= {6'h00, 7'h00, calib_disable, wiper_write_unlock,
                             1'b0};   // see RULE_07
            end
         end
      end
   end

   // Release-mode arming: 0x8001 then a NOP frame
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hiz_arm_q <= 1'b0;
         hiz_q     <= 1'b0;
      end else if (clk_en) begin
         if (decode) begin
            hiz_arm_q <= (shift_q == pot_pkg::HIZ_PREP_WORD);
            // Sticky: only rst_b brings the output back; pin and command resets do not
            hiz_q     <= hiz_q | (hiz_arm_q & dec_nop);   // see RULE_20
         end
      end
   end

   // Output shift: first bit shown at select fall, then advance on rising clock
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         out_sr_q     <= '0;
         out_bit_q    <= 1'b1;
         first_rise_q <= 1'b0;
      end else if (clk_en) begin
         if (sel_fall) begin
            out_sr_q     <= next_word;   // see RULE_18, RULE_19
            out_bit_q    <= next_word[15];
            first_rise_q <= 1'b1;
         end else if (!sel_b_s && sclk_rise) begin
            // Chained parts pass the received stream through after 16 bits;
            // the newest input bit enters here and leaves 15 rises later
            out_sr_q     <= first_rise_q ? out_sr_q : {out_sr_q[14:0], shift_q[0]};  // see RULE_22
            out_bit_q    <= first_rise_q ? out_bit_q : out_sr_q[14];   // see RULE_17
            first_rise_q <= 1'b0;
         end else if (sel_b_s) begin
            out_bit_q <= 1'b1;
         end
      end
   end

   assign serial_out_o  = 1'b0;   // see RULE_21
   assign serial_out_oe = ~out_bit_q & ~hiz_q;

   // Ready: drops on a decoded wiper write, wiper read or control read, returns after internal delay
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdy_cnt_q <= '0;
         rdy_q     <= 1'b1;
      end else if (clk_en) begin
         // A new wiper write or readback mid-count restarts the busy time
         if (dec_wiper_wr || dec_any_rd) begin
            rdy_q     <= 1'b0;
            rdy_cnt_q <= pot_pkg::RDY_DELAY_CYC;
         end else if (rdy_cnt_q != 4'h0) begin
            rdy_cnt_q <= rdy_cnt_q - 4'h1;
            rdy_q     <= (rdy_cnt_q == 4'h1);   // see RULE_14, RULE_15, RULE_16
         end
      end
   end

   // Open-drain ready: release for high
   assign ready_o  = 1'b0;
   assign ready_oe = ~rdy_q;
endmodule

// File: pot_serial_decoder_asserts.sv
`timescale 1ns/10ps
module pot_serial_decoder_asserts (
   input wire logic       clk_sys,
   input wire logic       rst_b,
   input wire logic       frame_sel_b,
   input wire logic       hw_reset,
   input wire logic       serial_out_o,
   input wire logic       serial_out_oe,
   input wire logic       ready_o,
   input wire logic       ready_oe,
   input wire logic [9:0] wiper_position_reg,
   input wire logic       wiper_write_unlock,
   input wire logic       shutdown_q,
   input wire logic       term_a_open,
   input wire logic       wiper_to_b
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   property p_rdy_len;
      $rose(ready_oe) |-> ready_oe [*4] ##1 !ready_oe;
   endproperty
   a_rdy_len: assert property (p_rdy_len) else $error("busy length wrong");
   property p_wr_rdy;
      $changed(wiper_position_reg) && wiper_position_reg != 10'h200 |-> ##[0:4] ready_oe;
   endproperty
   a_wr_rdy: assert property (p_wr_rdy) else $error("no busy after write");
   property p_rdy_sel;
      $rose(ready_oe) |-> frame_sel_b && $past(frame_sel_b, 2);
   endproperty
   a_rdy_sel: assert property (p_rdy_sel) else $error("busy inside frame");
   property p_lock;
      !$past(wiper_write_unlock) && $changed(wiper_position_reg) |-> wiper_position_reg == 10'h200;
   endproperty
   a_lock: assert property (p_lock) else $error("locked wiper moved");
   // Hazard: a mid-frame update would act on a partial word
   property p_quiet;
      !frame_sel_b && $past(frame_sel_b, 6) == 1'b0 && !hw_reset && $past(hw_reset, 6) == 1'b0
         |-> $stable(wiper_position_reg) && $stable(wiper_write_unlock);
   endproperty
   a_quiet: assert property (p_quiet) else $error("update during frame");
   property p_shdn_hold;
      $changed(shutdown_q) |-> $stable(wiper_position_reg) && $stable(wiper_write_unlock);
   endproperty
   a_shdn_hold: assert property (p_shdn_hold) else $error("shutdown moved regs");
   property p_shdn_out;
      term_a_open == shutdown_q && wiper_to_b == shutdown_q;
   endproperty
   a_shdn_out: assert property (p_shdn_out) else $error("terminal switches wrong");
   property p_od;
      serial_out_o == 1'b0 && ready_o == 1'b0;
   endproperty
   a_od: assert property (p_od) else $error("open drain drove high");
   property p_idle_rel;
      frame_sel_b && $past(frame_sel_b, 3) |-> !serial_out_oe;
   endproperty
   a_idle_rel: assert property (p_idle_rel) else $error("data line held outside frame");
   c_shdn: cover property ($rose(shutdown_q));
   c_unl: cover property ($rose(wiper_write_unlock));
   c_rdy: cover property ($rose(ready_oe));
endmodule

bind pot_serial_decoder pot_serial_decoder_asserts pot_serial_decoder_asserts_inst (
   .clk_sys, .rst_b, .frame_sel_b, .hw_reset, .serial_out_o, .serial_out_oe, .ready_o, .ready_oe,
   .wiper_position_reg, .wiper_write_unlock, .shutdown_q, .term_a_open, .wiper_to_b);

// File: pot_host_model.sv
`timescale 1ns/10ps
module pot_host_model (
   input  wire logic clk_sys,
   input  wire logic serial_out_oe,
   output logic      sclk,
   output logic      frame_sel_b,
   output logic      din
);
   logic line;
   assign line = serial_out_oe ? 1'b0 : 1'b1; // Pull-up
   initial begin
      sclk = 1'b0;
      frame_sel_b = 1'b1;
      din = 1'b0;
   end
   // Data moves mid-low phase so it never races the synchronised clock fall
   task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] rx);
      rx = '0;
      @(negedge clk_sys);
      frame_sel_b = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         #80;
         din = w[i];
         #80;
         sclk = 1'b1;
         #160;
         // Sample just before the fall: the device moves its bit on the rise
         rx = {rx[30:0], line};
         sclk = 1'b0;
      end
      #160;
      frame_sel_b = 1'b1;
      din = ~din;
   endtask
endmodule

// File: pot_serial_decoder_tb_top.sv
`timescale 1ns/10ps
module pot_serial_decoder_tb_top;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic        hw_reset = 1'b0;
   logic        sclk, frame_sel_b, din, so_o, so_oe, rdy_o, rdy_oe, unl, cal, sd, ta, wb;
   logic [9:0]  wip;
   logic [31:0] seed = 32'h0000DB92;
   logic [31:0] rx;
   int          err_count = 0;
   int          checks = 0;
   int          m_wip = 'h200, m_unl, m_cal, m_sd, m_prev, m_rb, m_prep, m_hiz, m_skip = 1;
   always #20 clk_sys = ~clk_sys;
   pot_serial_decoder pot_serial_decoder_inst (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1),
      .sclk(sclk), .frame_sel_b(frame_sel_b), .din(din), .hw_reset(hw_reset),
      .serial_out_o(so_o), .serial_out_oe(so_oe), .ready_o(rdy_o), .ready_oe(rdy_oe),
      .wiper_position_reg(wip), .wiper_write_unlock(unl), .calib_disable(cal),
      .shutdown_q(sd), .term_a_open(ta), .wiper_to_b(wb));
   pot_host_model pot_host_model_inst (.clk_sys(clk_sys), .serial_out_oe(so_oe), .sclk(sclk),
      .frame_sel_b(frame_sel_b), .din(din));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic regs();
      chk({rdy_oe, ta, wb, sd, cal, unl, wip}, {1'b0, 1'(m_sd), 1'(m_sd), 1'(m_sd), 1'(m_cal),
         1'(m_unl), 10'(m_wip)});
   endtask
   task automatic frame(input logic [31:0] w, input int n);
      logic [15:0] e;
      logic [15:0] lw;
      lw = w[15:0];
      if (m_hiz) e = 16'hFFFF;
      else if (m_rb == 1) e = 16'(m_wip);
      else if (m_rb == 2) e = 16'(m_cal * 4 + m_unl * 2);
      else e = 16'(m_prev);
      pot_host_model_inst.xfer(w, n, rx);
      if (!m_skip && n >= 16) chk(rx[n-1 -: 16], e);
      if (n == 32) chk(rx[15:0], w[31:16]);
      m_skip = n % 16 != 0 || lw == 16'h8001;
      if (n % 16 == 0) begin
         if (m_prep && lw[13:10] == 4'h0) m_hiz = 1;
         m_prep = lw == 16'h8001;
         m_rb = lw[13:10] == 4'h2 ? 1 : lw[13:10] == 4'h7 ? 2 : 0;
         case (lw[13:10])
            4'h1: if (m_unl) m_wip = lw[9:0];
            4'h4: begin
               m_wip = 'h200;
               m_unl = 0;
               m_cal = 0;
            end
            4'h6: begin
               m_unl = lw[1];
               m_cal = lw[2];
            end
            4'h8: m_sd = lw[0];
            default: ;
         endcase
         m_prev = lw;
      end
      repeat (12) @(negedge clk_sys);
      regs();
   endtask
   task automatic wrap_up();
      if (err_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #1000000;
      err_count++;
      wrap_up();
   end
   initial begin
      repeat (5) @(negedge clk_sys);
      rst_b = 1'b1;
      repeat (4) @(negedge clk_sys);
      regs();
      frame(32'h0400 | (rnd() & 32'h3FF), 16);
      frame(32'h1802, 16);
      frame(32'h0500, 16);
      frame(32'h0800, 16);
      frame(32'h0000, 16);
      repeat (4) frame(32'h0400 | (rnd() & 32'h3FF), 16);
      frame(32'h1C00, 16);
      frame(32'h1800 | (rnd() & 32'h3FF), 16);
      frame(32'h1802, 16);
      frame(32'h2001, 16);
      frame(32'h0400 | (rnd() & 32'h3FF), 16);
      frame(32'h2000, 16);
      frame(32'h1000, 16);
      frame(32'h1806, 16);
      frame({rnd() & 32'h3FFF, 16'h07FF}, 32);
      frame(32'h0400, 8);
      @(negedge clk_sys);
      hw_reset = 1'b1;
      repeat (8) @(negedge clk_sys);
      hw_reset = 1'b0;
      repeat (8) @(negedge clk_sys);
      m_wip = 'h200;
      m_unl = 0;
      m_cal = 0;
      m_skip = 1;
      regs();
      frame(32'h8001, 16);
      frame(32'h0000, 16);
      frame(32'h0000, 16);
      wrap_up();
   end
endmodule
